//--- hdl/dcps_map.svh
`ifndef DCPS_MAP_SVH
`define DCPS_MAP_SVH
// nominal bit time and tolerated range, in ns
`define DCPS_BIT_NS 500
`define DCPS_BIT_CYC ((`DCPS_BIT_NS + 4) / 5)
// slowest tolerated rate 1.45 Mbit/s, bit time about 690 ns
`define DCPS_IDLE_NS 1380
`define DCPS_IDLE_CYC (`DCPS_IDLE_NS / 5)
// identifier with no forwarding
`define DCPS_ID_NONE 6'h00
`define DCPS_ID_W 6
`endif

//--- hdl/dcps_pkg.sv
package dcps_pkg;
  typedef enum logic [4:0] {
    DCPS_SLEEP = 5'b00001,
    DCPS_WAKE = 5'b00010,
    DCPS_WAKEOUT = 5'b00100,
    DCPS_IDLE = 5'b01000,
    DCPS_RESP = 5'b10000
  } dcps_state_e;
  typedef enum logic [1:0] {
    DCPS_SRC_NONE = 2'h0,
    DCPS_SRC_SLOW = 2'h1,
    DCPS_SRC_FAST = 2'h2,
    DCPS_SRC_CHAIN = 2'h3
  } dcps_src_e;
endpackage

//--- hdl/dcps_port_selector.sv
`timescale 1ns/1ps
`include "dcps_map.svh"
// Functional notes
// - serial unit uses one pin, auto direction
// - slow unit on pin zero, fast pin one
// - asleep, both shared pins receive only
// - wake on pin with supply ok enables serial
// - slow pin wake gives host below direction
// - serial wake disables pin io until rewake
// - chain wake keeps io, serial units off
// - slow wake emits wake on high side
// - fast wake emits wake on low side
// - each chain port drives and receives
// - repeat frames unless id zero, asleep, emitting wake or answering
// - forward direction follows wake side
// - act only on good crc, matching id
// - links run nominal 2 Mbit/s
// - requests pass away from the host
module dcps_port_selector (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic logicSupplyOk,
  input wire logic sleepReq,
  input wire logic [5:0] ownNodeNumber,
  input wire logic sharedPinZeroIn,
  output logic sharedPinZeroOut,
  output logic sharedPinZeroOe,
  input wire logic sharedPinOneIn,
  output logic sharedPinOneOut,
  output logic sharedPinOneOe,
  input wire logic ioZeroOut,
  input wire logic ioZeroOe,
  input wire logic ioOneOut,
  input wire logic ioOneOe,
  input wire logic highSideRx,
  input wire logic highSideWake,
  output logic highSideTx,
  output logic highSideTxEn,
  output logic highSideWakeOut,
  input wire logic lowSideRx,
  input wire logic lowSideWake,
  output logic lowSideTx,
  output logic lowSideTxEn,
  output logic lowSideWakeOut,
  input wire logic respActive,
  input wire logic respData,
  input wire logic frameDone,
  input wire logic crcGood,
  input wire logic [5:0] frameId,
  output logic serialRx,
  output logic frameAccept,
  output dcps_pkg::dcps_src_e wakeSource,
  output logic hostBelow,
  output logic hostAbove,
  output logic awake
);
  import dcps_pkg::*;

  dcps_state_e state_reg, state_next;
  dcps_src_e src_reg, src_next;
  logic [8:0] cnt_reg, cnt_next;
  logic acc_reg;
  logic txZero_reg, txOne_reg;

  // wake detection: a low on an idle-high serial pin, or a chain wake
  wire slowWake = !sharedPinZeroIn && logicSupplyOk;
  wire fastWake = !sharedPinOneIn && logicSupplyOk;
  wire chainWake = highSideWake || lowSideWake;
  wire isSleep = (state_reg == DCPS_SLEEP);
  wire serialMode = (src_reg == DCPS_SRC_SLOW) || (src_reg == DCPS_SRC_FAST);
  logic lowSeen_reg, lowSeen_next;
  wire below = (src_reg == DCPS_SRC_SLOW) || (src_reg == DCPS_SRC_CHAIN && lowSeen_reg);
  wire idOk = (ownNodeNumber != `DCPS_ID_NONE);
  wire fwdOn = !isSleep && idOk && (state_reg != DCPS_WAKEOUT);
  wire [8:0] bitCyc = 9'(`DCPS_BIT_CYC);
  wire [8:0] idleCyc = 9'(`DCPS_IDLE_CYC);

  // sequencing: wake, wait, emit wake toward chain after a serial wake, then idle
  always_comb begin
    state_next = state_reg;
    src_next = src_reg;
    cnt_next = cnt_reg;
    lowSeen_next = lowSeen_reg;
    case (state_reg)
      DCPS_SLEEP: begin
        cnt_next = 9'h000;
        if (slowWake) begin
          src_next = DCPS_SRC_SLOW;
          state_next = DCPS_WAKE;
        end else if (fastWake) begin
          src_next = DCPS_SRC_FAST;
          state_next = DCPS_WAKE;
        end else if (chainWake) begin
          src_next = DCPS_SRC_CHAIN;
          lowSeen_next = lowSideWake;
          state_next = DCPS_WAKE;
        end
      end
      DCPS_WAKE: begin
        cnt_next = cnt_reg + 9'h001;
        if (cnt_reg >= idleCyc) begin
          cnt_next = 9'h000;
          state_next = serialMode ? DCPS_WAKEOUT : DCPS_IDLE;
        end
      end
      DCPS_WAKEOUT: begin
        cnt_next = cnt_reg + 9'h001;
        if (cnt_reg >= bitCyc) begin
          state_next = DCPS_IDLE;
        end
      end
      DCPS_IDLE: begin
        if (respActive) begin
          state_next = DCPS_RESP;
        end
      end
      DCPS_RESP: begin
        if (!respActive) begin
          state_next = DCPS_IDLE;
        end
      end
      default: begin
        state_next = DCPS_SLEEP;
      end
    endcase
    if (sleepReq) begin
      state_next = DCPS_SLEEP;
      src_next = DCPS_SRC_NONE;
      lowSeen_next = 1'b0;
    end
  end

  // source and direction held until the next sleep
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= DCPS_SLEEP;
      src_reg <= DCPS_SRC_NONE;
      cnt_reg <= 9'h000;
      lowSeen_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      src_reg <= src_next;
      cnt_reg <= cnt_next;
      lowSeen_reg <= lowSeen_next;
    end
  end

  // serial transmit only while answering; otherwise the pin listens
  wire zeroSerial = (src_reg == DCPS_SRC_SLOW) && !isSleep;
  wire oneSerial = (src_reg == DCPS_SRC_FAST) && !isSleep;
  wire ioAllowed = (src_reg == DCPS_SRC_CHAIN) && !isSleep;
  wire zeroTx = zeroSerial && (state_reg == DCPS_RESP);
  wire oneTx = oneSerial && (state_reg == DCPS_RESP);
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      txZero_reg <= 1'b1;
      txOne_reg <= 1'b1;
    end else begin
      // load on the request, not the state, so the first answer bit is not lost
      txZero_reg <= (zeroSerial && respActive) ? respData : 1'b1;
      txOne_reg <= (oneSerial && respActive) ? respData : 1'b1;
    end
  end
  assign sharedPinZeroOe = zeroTx || (ioAllowed && ioZeroOe);
  assign sharedPinOneOe = oneTx || (ioAllowed && ioOneOe);
  assign sharedPinZeroOut = zeroTx ? txZero_reg : (ioAllowed && ioZeroOut);
  assign sharedPinOneOut = oneTx ? txOne_reg : (ioAllowed && ioOneOut);
  assign serialRx = zeroSerial ? sharedPinZeroIn : (oneSerial ? sharedPinOneIn : 1'b1);

  // forwarding: requests move away from the host; responses go both ways
  wire inResp = (state_reg == DCPS_RESP);
  wire fwdUp = fwdOn && below && !inResp;
  wire fwdDown = fwdOn && !below && !inResp;
  wire srcUpRx = serialMode ? serialRx : lowSideRx;
  wire srcDnRx = serialMode ? serialRx : highSideRx;
  assign highSideTxEn = fwdUp || inResp || (state_reg == DCPS_WAKEOUT && below);
  assign lowSideTxEn = fwdDown || inResp || (state_reg == DCPS_WAKEOUT && !below);
  assign highSideTx = inResp ? respData : (fwdUp ? srcUpRx : 1'b1);
  assign lowSideTx = inResp ? respData : (fwdDown ? srcDnRx : 1'b1);
  // slow wake means host below, so wake goes upward
  assign highSideWakeOut = (state_reg == DCPS_WAKEOUT) && (src_reg == DCPS_SRC_SLOW);
  assign lowSideWakeOut = (state_reg == DCPS_WAKEOUT) && (src_reg == DCPS_SRC_FAST);

  // frame acceptance registered for one cycle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      acc_reg <= 1'b0;
    end else begin
      acc_reg <= frameDone && crcGood && (frameId == ownNodeNumber) && !isSleep;
    end
  end
  assign frameAccept = acc_reg;
  assign wakeSource = src_reg;
  assign hostBelow = !isSleep && below;
  assign hostAbove = !isSleep && (src_reg != DCPS_SRC_NONE) && !below;
  assign awake = !isSleep;

  chk_sleep_quiet: assert property (@(posedge ref_clk) disable iff (srst)
    isSleep |-> !sharedPinZeroOe && !sharedPinOneOe) else $error("pin driven in sleep");
  chk_slow_dir: assert property (@(posedge ref_clk) disable iff (srst)
    isSleep && slowWake && !sleepReq |=> hostBelow) else $error("slow wake not below");
  chk_fast_dir: assert property (@(posedge ref_clk) disable iff (srst)
    isSleep && !slowWake && fastWake && !sleepReq |=> hostAbove) else $error("fast wake dir");
  chk_src_hold: assert property (@(posedge ref_clk) disable iff (srst)
    !isSleep && !sleepReq |=> $stable(src_reg)) else $error("source changed awake");
  chk_chain_io: assert property (@(posedge ref_clk) disable iff (srst)
    src_reg == DCPS_SRC_CHAIN |-> !zeroTx && !oneTx) else $error("serial on chain wake");
  chk_wake_high: assert property (@(posedge ref_clk) disable iff (srst)
    highSideWakeOut |-> highSideTxEn && src_reg == DCPS_SRC_SLOW) else $error("bad high wake");
  chk_wake_low: assert property (@(posedge ref_clk) disable iff (srst)
    lowSideWakeOut |-> lowSideTxEn && src_reg == DCPS_SRC_FAST) else $error("bad low wake");
  chk_no_fwd: assert property (@(posedge ref_clk) disable iff (srst)
    !idOk && !inResp && !highSideWakeOut && !lowSideWakeOut |-> !highSideTxEn && !lowSideTxEn)
    else $error("forward with id zero");
  chk_accept: assert property (@(posedge ref_clk) disable iff (srst)
    frameAccept |-> $past(frameDone) && $past(crcGood) && $past(frameId) == $past(ownNodeNumber))
    else $error("bad accept");
  chk_resp_pin: assert property (@(posedge ref_clk) disable iff (srst)
    inResp && zeroSerial |-> sharedPinZeroOe && !sharedPinOneOe) else $error("answer pin off");
  chk_fwd_dir: assert property (@(posedge ref_clk) disable iff (srst)
    fwdUp |-> !lowSideTxEn) else $error("forward both ways");
endmodule

//--- tb/dcps_host_model.sv
`timescale 1ns/1ps
// host side of the shared serial pins; a line not in use idles high
module dcps_host_model (
  input wire logic ref_clk,
  input wire logic [1:0] txSel,
  input wire logic txBit,
  output logic pinZero,
  output logic pinOne
);
  // registered so the bits change only on clock edges, like a real uart
  always_ff @(posedge ref_clk) begin
    pinZero <= (txSel == 2'h1) ? txBit : 1'b1;
    pinOne <= (txSel == 2'h2) ? txBit : 1'b1;
  end
endmodule

//--- tb/test_dcps_port_selector.sv
`timescale 1ns/1ps
module test_dcps_port_selector;
  import dcps_pkg::*;
  logic ref_clk = 1'b0, srst = 1'b1, logicSupplyOk = 1'b1, sleepReq = 1'b0;
  logic [5:0] ownNodeNumber = 6'h05, frameId = 6'h00;
  logic ioZeroOut = 1'b0, ioZeroOe = 1'b0, ioOneOut = 1'b0, ioOneOe = 1'b0;
  logic highSideRx = 1'b1, highSideWake = 1'b0, lowSideRx = 1'b1, lowSideWake = 1'b0;
  logic frameDone = 1'b0, crcGood = 1'b0, txBit = 1'b1;
  logic respActive = 1'b0, respData = 1'b0;
  logic [1:0] txSel = 2'h0;
  logic hostZero, hostOne, pZeroOut, pZeroOe, pOneOut, pOneOe, serialRx, frameAccept;
  logic highSideTx, highSideTxEn, highSideWakeOut, lowSideTx, lowSideTxEn, lowSideWakeOut;
  logic hostBelow, hostAbove, awake;
  dcps_src_e wakeSource;
  int errCount = 0;
  int numChecks = 0;
  int seed = 32'hcc67;
  int n;
  // pin level resolved from whoever drives it
  wire logic pinZero = pZeroOe ? pZeroOut : hostZero;
  wire logic pinOne = pOneOe ? pOneOut : hostOne;
  always #2.5 ref_clk = ~ref_clk;
  dcps_host_model u_dcps_host_model (.ref_clk(ref_clk), .txSel(txSel), .txBit(txBit),
    .pinZero(hostZero), .pinOne(hostOne));
  dcps_port_selector u_dcps_port_selector (.ref_clk(ref_clk), .srst(srst),
    .logicSupplyOk(logicSupplyOk), .sleepReq(sleepReq), .ownNodeNumber(ownNodeNumber),
    .sharedPinZeroIn(pinZero), .sharedPinZeroOut(pZeroOut), .sharedPinZeroOe(pZeroOe),
    .sharedPinOneIn(pinOne), .sharedPinOneOut(pOneOut), .sharedPinOneOe(pOneOe),
    .ioZeroOut(ioZeroOut), .ioZeroOe(ioZeroOe), .ioOneOut(ioOneOut), .ioOneOe(ioOneOe),
    .highSideRx(highSideRx), .highSideWake(highSideWake), .highSideTx(highSideTx),
    .highSideTxEn(highSideTxEn), .highSideWakeOut(highSideWakeOut), .lowSideRx(lowSideRx),
    .lowSideWake(lowSideWake), .lowSideTx(lowSideTx), .lowSideTxEn(lowSideTxEn),
    .lowSideWakeOut(lowSideWakeOut), .respActive(respActive), .respData(respData),
    .frameDone(frameDone), .crcGood(crcGood), .frameId(frameId), .serialRx(serialRx),
    .frameAccept(frameAccept), .wakeSource(wakeSource), .hostBelow(hostBelow),
    .hostAbove(hostAbove), .awake(awake));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    numChecks++;
    if (got !== exp) begin
      errCount++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finishTest;
    $display("checks=%0d mismatches=%0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // inputs always move 1 ns after the rising edge
  task automatic step;
    @(posedge ref_clk);
    #1;
  endtask
  // bounded wait for either wake emission to reach a level
  task automatic waitWo(input logic lvl);
    n = 0;
    while ((highSideWakeOut | lowSideWakeOut) !== lvl && n < 400) begin
      step();
      n++;
    end
    if (n >= 400) begin
      errCount++;
      finishTest();
    end
  endtask
  // wake via a shared pin; io requests stay high to show they are ignored
  task automatic serialWake(input logic fast);
    logic [1:0] fwdPair;
    txSel = fast ? 2'h2 : 2'h1;
    txBit = 1'b0;
    ioZeroOe = 1'b1;
    ioOneOe = 1'b1;
    repeat (2) step();
    txSel = 2'h0;
    chk({6'h0, wakeSource}, fast ? 8'h2 : 8'h1);
    chk({6'h0, hostBelow, hostAbove}, fast ? 8'h1 : 8'h2);
    waitWo(1'b1);
    chk({6'h0, highSideWakeOut, lowSideWakeOut}, fast ? 8'h1 : 8'h2);
    chk({6'h0, highSideTxEn, lowSideTxEn}, fast ? 8'h1 : 8'h2);
    waitWo(1'b0);
    chk(n[7:0], 8'd101);
    txSel = fast ? 2'h2 : 2'h1;
    repeat (8) begin
      txBit = 1'($random(seed));
      step();
      fwdPair = fast ? {lowSideTx, lowSideTxEn} : {highSideTx, highSideTxEn};
      chk({4'h0, fwdPair, pZeroOe, pOneOe}, {4'h0, txBit, 3'b100});
    end
    txSel = 2'h0;
  endtask
  task automatic frame(input logic good, input logic [5:0] id, input logic exp);
    frameDone = 1'b1;
    crcGood = good;
    frameId = id;
    step();
    frameDone = 1'b0;
    chk({7'h0, frameAccept}, {7'h0, exp});
    step();
  endtask
  // sleep must drop every driver even with io requests still high
  task automatic goSleep;
    sleepReq = 1'b1;
    step();
    sleepReq = 1'b0;
    step();
    chk({awake, pZeroOe, pOneOe, highSideTxEn, lowSideTxEn, 1'b0, wakeSource}, 8'h0);
  endtask
  initial begin
    #100000;
    errCount++;
    finishTest();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    #1 srst = 1'b0;
    logicSupplyOk = 1'b0;
    txSel = 2'h1;
    txBit = 1'b0;
    repeat (3) step();
    chk({7'h0, awake}, 8'h0);
    txSel = 2'h0;
    step();
    logicSupplyOk = 1'b1;
    $display("test supply_low done");
    serialWake(1'b0);
    frame(1'b1, ownNodeNumber, 1'b1);
    frame(1'b1, ownNodeNumber ^ 6'h01, 1'b0);
    frame(1'b0, ownNodeNumber, 1'b0);
    // own answer: pin zero turns to transmit, both chain ports drive
    respActive = 1'b1;
    repeat (6) begin
      respData = 1'($random(seed));
      step();
      chk({5'h0, pZeroOe, pZeroOut, highSideTx}, {5'h0, 1'b1, respData, respData});
      chk({6'h0, highSideTxEn, lowSideTxEn}, 8'h3);
    end
    respActive = 1'b0;
    respData = 1'b0;
    step();
    chk({6'h0, pZeroOe, lowSideTxEn}, 8'h0);
    goSleep();
    $display("test slow_wake done");
    ownNodeNumber = 6'($random(seed)) | 6'h01;
    serialWake(1'b1);
    goSleep();
    $display("test fast_wake done");
    lowSideWake = 1'b1;
    step();
    lowSideWake = 1'b0;
    chk({5'h0, hostBelow, wakeSource}, 8'h7);
    // no completion flag exists, so wait out the fixed wake time
    repeat (300) step();
    repeat (8) begin
      ioZeroOut = 1'($random(seed));
      lowSideRx = 1'($random(seed));
      step();
      chk({6'h0, pZeroOe, pZeroOut}, {6'h1, ioZeroOut});
      chk({6'h0, highSideTx, highSideTxEn}, {6'h0, lowSideRx, 1'b1});
      chk({6'h0, highSideWakeOut, lowSideWakeOut}, 8'h0);
    end
    ownNodeNumber = 6'h00;
    step();
    chk({6'h0, highSideTxEn, lowSideTxEn}, 8'h0);
    goSleep();
    $display("test chain_wake done");
    // wake from above: requests run from high side down to low side
    ownNodeNumber = 6'h2a;
    highSideWake = 1'b1;
    step();
    highSideWake = 1'b0;
    chk({5'h0, hostAbove, wakeSource}, 8'h7);
    repeat (300) step();
    repeat (4) begin
      highSideRx = 1'($random(seed));
      step();
      chk({4'h0, lowSideTx, lowSideTxEn, highSideTxEn, pOneOe}, {4'h0, highSideRx, 3'b101});
    end
    goSleep();
    $display("test chain_high done");
    finishTest();
  end
endmodule
